// [pkg/acctr_pkg.sv]
// Operation
// - channels 16-21 differential select at odd bits 11..1; 1 differential.
// - channels 16-21 sign select at even bits 10..0; 1 signed.
// - input mode register bits 15..12 read as zero.
// - one interrupt enable per channel, 0-15 low, 16-21 high bits 5..0.
// - read-only ready flag per channel, set when a result is buffered.
// - high enable and ready registers read zero in bits 15..6.
// - trigger register x: low byte holds channel 2x, high byte channel 2x+1.
// - code 0 none, 1 common software, 2 level software, 3 reserved.
// - code 4 PWM special event, 5..10 PWM generators 1..6 primary.
// - code 11 logic cell one, 12 timer 1, 13 timer 2 period match.
// - code 14 PWM secondary special event, 15..20 generators 1..6 secondary.
// - code 21 logic cell two, 22 output compare 1, 23 output compare 2.
// - codes 24..29 select PWM generators 1..6 current-limit triggers.
// - code 30 pattern trigger generator, 31 external trigger input.
// - trigger registers read zero in bits 15..13 and 7..5.
// - calibration register: core 1 bits 15,10,9,8; core 0 bits 7,2,1,0.
// - writing 1 to start begins calibration; hardware clears it when done. The code starts only if enable was already set before that write.
// - done flag is 0 during calibration, 1 once finished.
// - calibration differential_select select picks differential or single-ended calibration.
package acctr_pkg;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int ACCTR_ADDR_W     = 8;
	localparam int ACCTR_NUM_CH     = 22;
	localparam int ACCTR_LO_CH      = 16;
	localparam int ACCTR_MODE_W     = 12;
	localparam int ACCTR_NUM_FIELD  = 24;
	localparam int ACCTR_SRC_W      = 5;
	localparam int ACCTR_NUM_CORE   = 2;
	localparam int ACCTR_TRIG_REGS  = 12;
	localparam int ACCTR_SYNC_W     = 3;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ACCTR_OFS_MODE   = 8'h00;
	localparam logic [7:0] ACCTR_OFS_IE_LO  = 8'h04;
	localparam logic [7:0] ACCTR_OFS_IE_HI  = 8'h08;
	localparam logic [7:0] ACCTR_OFS_RDY_LO = 8'h0C;
	localparam logic [7:0] ACCTR_OFS_RDY_HI = 8'h10;
	localparam logic [7:0] ACCTR_OFS_CAL    = 8'h14;
	localparam logic [7:0] ACCTR_OFS_SWTRG  = 8'h18;
	localparam logic [7:0] ACCTR_OFS_TRIG   = 8'h20;
	localparam logic [7:0] ACCTR_LANE_MASK  = 8'h03;
	localparam int         ACCTR_WORD_LSB   = 2;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int ACCTR_MODE_SIGN   = 0;
	localparam int ACCTR_MODE_DIFFERENTIAL_SELECT   = 1;
	localparam int ACCTR_FLD_EVEN    = 0;
	localparam int ACCTR_FLD_ODD     = 8;
	localparam int ACCTR_CAL_START   = 0;
	localparam int ACCTR_CAL_EN      = 1;
	localparam int ACCTR_CAL_DIFFERENTIAL_SELECT    = 2;
	localparam int ACCTR_CAL_DONE    = 7;
	localparam int ACCTR_CAL_STRIDE  = 8;
	localparam int ACCTR_SW_COMMON   = 0;
	localparam int ACCTR_SW_LEVEL    = 1;
	// ------------------------------------------------------------
	// trigger source codes
	// ------------------------------------------------------------
	localparam logic [4:0] ACCTR_TRG_NONE        = 5'h00;
	localparam logic [4:0] ACCTR_TRG_COMMON_SW   = 5'h01;
	localparam logic [4:0] ACCTR_TRG_LEVEL_SW    = 5'h02;
	localparam logic [4:0] ACCTR_TRG_RESERVED    = 5'h03;
	localparam logic [4:0] ACCTR_TRG_PWM_SPECIAL = 5'h04;
	localparam logic [4:0] ACCTR_TRG_PWM_PRI1    = 5'h05;
	localparam logic [4:0] ACCTR_TRG_CELL_ONE    = 5'h0B;
	localparam logic [4:0] ACCTR_TRG_TMR1        = 5'h0C;
	localparam logic [4:0] ACCTR_TRG_TMR2        = 5'h0D;
	localparam logic [4:0] ACCTR_TRG_PWM_SEC_SPC = 5'h0E;
	localparam logic [4:0] ACCTR_TRG_PWM_SEC1    = 5'h0F;
	localparam logic [4:0] ACCTR_TRG_CELL_TWO    = 5'h15;
	localparam logic [4:0] ACCTR_TRG_OC1         = 5'h16;
	localparam logic [4:0] ACCTR_TRG_OC2         = 5'h17;
	localparam logic [4:0] ACCTR_TRG_PWM_CL1     = 5'h18;
	localparam logic [4:0] ACCTR_TRG_PATTERN     = 5'h1E;
	localparam logic [4:0] ACCTR_TRG_EXT         = 5'h1F;
	localparam int         ACCTR_PWM_GENS        = 6;
	// ------------------------------------------------------------
	// bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] ACCTR_RESP_OKAY   = 2'h0;
	localparam logic [1:0] ACCTR_RESP_SLVERR = 2'h2;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic                      pwm_special;
		logic [ACCTR_PWM_GENS-1:0] pwm_primary;
		logic                      cell_one;
		logic                      tmr1;
		logic                      tmr2;
		logic                      pwm_sec_special;
		logic [ACCTR_PWM_GENS-1:0] pwm_secondary;
		logic                      cell_two;
		logic                      oc1;
		logic                      oc2;
		logic [ACCTR_PWM_GENS-1:0] pwm_climit;
		logic                      pattern;
	} acctr_evt_t;

	typedef struct packed {
		logic [ACCTR_MODE_W-1:0]                      mode;
		logic [ACCTR_NUM_CH-1:0]                      irq_en;
		logic [ACCTR_NUM_CH-1:0]                      ready;
		logic [ACCTR_NUM_FIELD-1:0][ACCTR_SRC_W-1:0]  trig_sel;
		logic [ACCTR_NUM_CORE-1:0]                    cal_differential_select;
		logic [ACCTR_NUM_CORE-1:0]                    cal_en;
		logic [ACCTR_NUM_CORE-1:0]                    cal_start;
		logic [ACCTR_NUM_CORE-1:0]                    cal_done;
		logic [ACCTR_NUM_CORE-1:0]                    cal_pulse;
		logic                                         sw_common;
		logic                                         sw_level;
		logic [ACCTR_SYNC_W-1:0]                      ext_sync;
		logic                                         ext_q;
		logic [ACCTR_NUM_CH-1:0]                      trig_out;
		logic                                         aw_full;
		logic [ACCTR_ADDR_W-1:0]                      aw_addr;
		logic                                         w_full;
		logic [15:0]                                  w_data;
		logic [1:0]                                   w_strb;
		logic                                         bvalid;
		logic [1:0]                                   bresp;
		logic                                         rvalid;
		logic [1:0]                                   rresp;
		logic [31:0]                                  rdata;
	} acctr_state_t;
endpackage

// [src/acctr_regs.sv]
`timescale 1ns/1ns
module acctr_regs
	import acctr_pkg::*;
(
	// clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// axi4-lite write
	input  wire logic [ACCTR_ADDR_W-1:0]       awaddr,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	// axi4-lite read
	input  wire logic [ACCTR_ADDR_W-1:0]       araddr,
	input  wire logic                          arvalid,
	output logic                               arready,
	output logic [31:0]                        rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire logic                          rready,
	// trigger events
	input  wire acctr_evt_t                    trigger_events,
	input  wire logic                          external_trigger_input,
	// conversion results
	input  wire logic [ACCTR_NUM_CH-1:0]       result_done,
	input  wire logic [ACCTR_NUM_CH-1:0]       buffer_read,
	// calibration cores
	input  wire logic [ACCTR_NUM_CORE-1:0]     cal_finished,
	output logic [ACCTR_NUM_CORE-1:0]          core_cal_start,
	output logic [ACCTR_NUM_CORE-1:0]          core_cal_diffmode,
	// channel configuration
	output logic [ACCTR_MODE_W/2-1:0]          differential_select,
	output logic [ACCTR_MODE_W/2-1:0]          sign_select,
	output logic [ACCTR_NUM_CH-1:0]            channel_irq_enable,
	output logic [ACCTR_NUM_CH-1:0]            result_ready_flag,
	output logic [ACCTR_NUM_CH-1:0]            channel_trigger
);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	if (ACCTR_NUM_CH > ACCTR_NUM_FIELD || ACCTR_NUM_CH <= ACCTR_LO_CH) begin : g_chk
		$error("channel count does not fit the trigger and enable layout");
	end

	acctr_state_t st_reg;
	acctr_state_t st_next;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
		input logic [1:0] strb);
		logic [15:0] m;
		m = {{8{strb[1]}}, {8{strb[0]}}};
		return (old_v & ~m) | (new_v & m);
	endfunction

	function automatic logic [ACCTR_ADDR_W-ACCTR_WORD_LSB-1:0] trig_index(
		input logic [ACCTR_ADDR_W-1:0] a);
		logic [ACCTR_ADDR_W-1:0] t;
		t = a - ACCTR_OFS_TRIG;
		return t[ACCTR_ADDR_W-1:ACCTR_WORD_LSB];
	endfunction

	function automatic logic is_trig(input logic [ACCTR_ADDR_W-1:0] a);
		return (a >= ACCTR_OFS_TRIG) && (32'(trig_index(a)) < ACCTR_TRIG_REGS);
	endfunction

	// returns {hit, data}; unimplemented bits stay zero
	function automatic logic [16:0] read_reg(input acctr_state_t s,
		input logic [ACCTR_ADDR_W-1:0] a);
		logic [15:0]                            d;
		logic                                   hit;
		logic [ACCTR_ADDR_W-ACCTR_WORD_LSB-1:0] idx;
		d   = '0;
		hit = 1'b1;
		idx = trig_index(a);
		if (a == ACCTR_OFS_MODE) begin
			d = 16'(s.mode);
		end else if (a == ACCTR_OFS_IE_LO) begin
			d = s.irq_en[ACCTR_LO_CH-1:0];
		end else if (a == ACCTR_OFS_IE_HI) begin
			d = 16'(s.irq_en[ACCTR_NUM_CH-1:ACCTR_LO_CH]);
		end else if (a == ACCTR_OFS_RDY_LO) begin
			d = s.ready[ACCTR_LO_CH-1:0];
		end else if (a == ACCTR_OFS_RDY_HI) begin
			d = 16'(s.ready[ACCTR_NUM_CH-1:ACCTR_LO_CH]);
		end else if (a == ACCTR_OFS_CAL) begin
			for (int c = 0; c < ACCTR_NUM_CORE; c++) begin
				d[c*ACCTR_CAL_STRIDE+ACCTR_CAL_EN] = s.cal_en[c];
				if (s.cal_en[c]) begin
					d[c*ACCTR_CAL_STRIDE+ACCTR_CAL_DONE]  = s.cal_done[c];
					d[c*ACCTR_CAL_STRIDE+ACCTR_CAL_DIFFERENTIAL_SELECT]  = s.cal_differential_select[c];
					d[c*ACCTR_CAL_STRIDE+ACCTR_CAL_START] = s.cal_start[c];
				end
			end
		end else if (a == ACCTR_OFS_SWTRG) begin
			d[ACCTR_SW_LEVEL] = s.sw_level;
		end else if (is_trig(a)) begin
			d[ACCTR_FLD_EVEN +: ACCTR_SRC_W] = s.trig_sel[2*idx];
			d[ACCTR_FLD_ODD +: ACCTR_SRC_W]  = s.trig_sel[2*idx+1];
		end else begin
			hit = 1'b0;
		end
		return {hit, d};
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [16:0]                            rd;
		logic [15:0]                            nv;
		logic [ACCTR_ADDR_W-ACCTR_WORD_LSB-1:0] idx;
		logic [31:0]                            src;
		logic [ACCTR_ADDR_W-1:0]                wa;
		rd  = '0;
		nv  = '0;
		src = '0;
		wa  = st_reg.aw_addr & ~ACCTR_LANE_MASK;
		idx = trig_index(wa);
		st_next = st_reg;
		st_next.cal_pulse = '0;
		st_next.sw_common = 1'b0;

		// write address and data are taken in either order
		if (awvalid && awready) begin
			st_next.aw_full = 1'b1;
			st_next.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			st_next.w_full = 1'b1;
			st_next.w_data = wdata[15:0];
			st_next.w_strb = wstrb[1:0];
		end
		if (st_reg.bvalid && bready) begin
			st_next.bvalid = 1'b0;
		end

		// commit once both halves are held
		if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin
			st_next.aw_full = 1'b0;
			st_next.w_full  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = ACCTR_RESP_OKAY;
			if (wa == ACCTR_OFS_MODE) begin
				nv = merge16(16'(st_reg.mode), st_reg.w_data, st_reg.w_strb);
				st_next.mode = nv[ACCTR_MODE_W-1:0];
			end else if (wa == ACCTR_OFS_IE_LO) begin
				nv = merge16(st_reg.irq_en[ACCTR_LO_CH-1:0], st_reg.w_data, st_reg.w_strb);
				st_next.irq_en[ACCTR_LO_CH-1:0] = nv;
			end else if (wa == ACCTR_OFS_IE_HI) begin
				nv = merge16(16'(st_reg.irq_en[ACCTR_NUM_CH-1:ACCTR_LO_CH]),
					st_reg.w_data, st_reg.w_strb);
				st_next.irq_en[ACCTR_NUM_CH-1:ACCTR_LO_CH] =
					nv[ACCTR_NUM_CH-ACCTR_LO_CH-1:0];
			end else if (wa == ACCTR_OFS_RDY_LO || wa == ACCTR_OFS_RDY_HI) begin
				// ready flags belong to hardware; writes are dropped
				st_next.bresp = ACCTR_RESP_OKAY;
			end else if (wa == ACCTR_OFS_CAL) begin
				nv = merge16(st_reg.w_data, st_reg.w_data, st_reg.w_strb);
				for (int c = 0; c < ACCTR_NUM_CORE; c++) begin
					if (st_reg.w_strb[c]) begin
						st_next.cal_en[c] = nv[c*ACCTR_CAL_STRIDE+ACCTR_CAL_EN];
						// gated by the enable held before this write
						if (st_reg.cal_en[c]) begin
							st_next.cal_differential_select[c] =
								nv[c*ACCTR_CAL_STRIDE+ACCTR_CAL_DIFFERENTIAL_SELECT];
							if (nv[c*ACCTR_CAL_STRIDE+ACCTR_CAL_START] &&
								!st_reg.cal_start[c]) begin
								st_next.cal_start[c] = 1'b1;
								st_next.cal_done[c]  = 1'b0;
								st_next.cal_pulse[c] = 1'b1;
							end
						end
					end
				end
			end else if (wa == ACCTR_OFS_SWTRG) begin
				if (st_reg.w_strb[0]) begin
					st_next.sw_common = st_reg.w_data[ACCTR_SW_COMMON];
					st_next.sw_level  = st_reg.w_data[ACCTR_SW_LEVEL];
				end
			end else if (is_trig(wa)) begin
				nv = merge16({3'h0, st_reg.trig_sel[2*idx+1], 3'h0, st_reg.trig_sel[2*idx]},
					st_reg.w_data, st_reg.w_strb);
				st_next.trig_sel[2*idx]   = nv[ACCTR_FLD_EVEN +: ACCTR_SRC_W];
				st_next.trig_sel[2*idx+1] = nv[ACCTR_FLD_ODD +: ACCTR_SRC_W];
			end else begin
				st_next.bresp = ACCTR_RESP_SLVERR;
			end
		end

		// read answers one cycle after the address is taken
		if (st_reg.rvalid && rready) begin
			st_next.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			rd = read_reg(st_reg, araddr & ~ACCTR_LANE_MASK);
			st_next.rvalid = 1'b1;
			st_next.rdata  = 32'(rd[15:0]);
			st_next.rresp  = rd[16] ? ACCTR_RESP_OKAY : ACCTR_RESP_SLVERR;
		end

		// calibration completion; done set wins over a clearing start
		for (int c = 0; c < ACCTR_NUM_CORE; c++) begin
			if (cal_finished[c] && st_reg.cal_start[c]) begin
				st_next.cal_start[c] = 1'b0;
				st_next.cal_done[c]  = 1'b1;
			end
		end

		// a new result wins over a buffer read in the same cycle
		st_next.ready = (st_reg.ready & ~buffer_read) | result_done;

		// external pin: three stages, change taken when last two agree
		st_next.ext_sync = {st_reg.ext_sync[ACCTR_SYNC_W-2:0], external_trigger_input};
		if (st_reg.ext_sync[ACCTR_SYNC_W-1] == st_reg.ext_sync[ACCTR_SYNC_W-2]) begin
			st_next.ext_q = st_reg.ext_sync[ACCTR_SYNC_W-1];
		end

		// source vector indexed by trigger code
		src[ACCTR_TRG_NONE]        = 1'b0;
		src[ACCTR_TRG_COMMON_SW]   = st_reg.sw_common;
		src[ACCTR_TRG_LEVEL_SW]    = st_reg.sw_level;
		src[ACCTR_TRG_RESERVED]    = 1'b0;
		src[ACCTR_TRG_PWM_SPECIAL] = trigger_events.pwm_special;
		src[ACCTR_TRG_CELL_ONE]    = trigger_events.cell_one;
		src[ACCTR_TRG_TMR1]        = trigger_events.tmr1;
		src[ACCTR_TRG_TMR2]        = trigger_events.tmr2;
		src[ACCTR_TRG_PWM_SEC_SPC] = trigger_events.pwm_sec_special;
		src[ACCTR_TRG_CELL_TWO]    = trigger_events.cell_two;
		src[ACCTR_TRG_OC1]         = trigger_events.oc1;
		src[ACCTR_TRG_OC2]         = trigger_events.oc2;
		src[ACCTR_TRG_PATTERN]     = trigger_events.pattern;
		src[ACCTR_TRG_EXT]         = st_reg.ext_q;
		for (int g = 0; g < ACCTR_PWM_GENS; g++) begin
			src[32'(ACCTR_TRG_PWM_PRI1) + g] = trigger_events.pwm_primary[g];
			src[32'(ACCTR_TRG_PWM_SEC1) + g] = trigger_events.pwm_secondary[g];
			src[32'(ACCTR_TRG_PWM_CL1) + g]  = trigger_events.pwm_climit[g];
		end
		// fields past the last channel are stored but drive nothing
		for (int ch = 0; ch < ACCTR_NUM_CH; ch++) begin
			st_next.trig_out[ch] = src[st_reg.trig_sel[ch]];
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign awready = !st_reg.aw_full && !st_reg.bvalid;
	assign wready  = !st_reg.w_full && !st_reg.bvalid;
	assign bvalid  = st_reg.bvalid;
	assign bresp   = st_reg.bresp;
	assign arready = !st_reg.rvalid;
	assign rvalid  = st_reg.rvalid;
	assign rdata   = st_reg.rdata;
	assign rresp   = st_reg.rresp;

	assign core_cal_start     = st_reg.cal_pulse;
	assign core_cal_diffmode  = st_reg.cal_differential_select;
	assign channel_irq_enable = st_reg.irq_en;
	assign result_ready_flag  = st_reg.ready;
	assign channel_trigger    = st_reg.trig_out;

	for (genvar k = 0; k < ACCTR_MODE_W/2; k++) begin : g_mode
		assign differential_select[k] = st_reg.mode[2*k+ACCTR_MODE_DIFFERENTIAL_SELECT];
		assign sign_select[k]         = st_reg.mode[2*k+ACCTR_MODE_SIGN];
	end

endmodule // acctr_regs

// [tb/acctr_regs_checker.sv]
`timescale 1ns/1ns
module acctr_regs_checker
	import acctr_pkg::*;
(
	// clock and reset
	input wire logic                      aclk,
	input wire logic                      aresetn,
	// register bus
	input wire logic [ACCTR_ADDR_W-1:0]   araddr,
	input wire logic                      arvalid,
	input wire logic                      arready,
	input wire logic [31:0]               rdata,
	input wire logic                      rvalid,
	input wire logic [1:0]                bresp,
	input wire logic                      bvalid,
	input wire logic                      bready,
	// side band
	input wire logic [ACCTR_NUM_CH-1:0]   result_done,
	input wire logic [ACCTR_NUM_CH-1:0]   buffer_read,
	input wire logic [ACCTR_NUM_CORE-1:0] core_cal_start,
	input wire logic [ACCTR_NUM_CH-1:0]   channel_irq_enable,
	input wire logic [ACCTR_NUM_CH-1:0]   result_ready_flag,
	input wire logic [ACCTR_NUM_CH-1:0]   channel_trigger
);
	// ------------------------------------------------------------
	// read address tracking
	// ------------------------------------------------------------
	logic [7:0] a_reg;
	logic [7:0] a_q;
	assign a_q = {a_reg[7:2], 2'b00};
	always_ff @(posedge aclk) begin
		if (!aresetn)
			a_reg <= 8'h00;
		else if (arvalid && arready)
			a_reg <= araddr;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	chk_read_next: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	chk_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	chk_mode_top: assert property (rvalid && a_q == ACCTR_OFS_MODE
		|-> rdata[31:12] == 20'h00000)
		else $error("mode upper bits set");
	chk_high_top: assert property (rvalid
		&& (a_q == ACCTR_OFS_IE_HI || a_q == ACCTR_OFS_RDY_HI)
		|-> rdata[31:6] == 26'h0000000)
		else $error("high register upper bits set");
	chk_trig_gaps: assert property (rvalid && a_q >= ACCTR_OFS_TRIG && a_q < 8'h50
		|-> rdata[15:13] == 3'h0 && rdata[7:5] == 3'h0)
		else $error("trigger gap bits set");
	chk_cal_gaps: assert property (rvalid && a_q == ACCTR_OFS_CAL
		|-> rdata[14:11] == 4'h0 && rdata[6:3] == 4'h0)
		else $error("calibration gap bits set");
	chk_ready_set: assert property (result_done != 0
		|=> (result_ready_flag & $past(result_done)) == $past(result_done))
		else $error("ready flag not set");
	chk_ready_clear: assert property (buffer_read != 0 && result_done == 0
		|=> (result_ready_flag & $past(buffer_read)) == 0)
		else $error("ready flag not cleared");
	chk_cal_start: assert property (core_cal_start != 0 |-> $rose(bvalid))
		else $error("calibration start off the commit");
	chk_irq_commit: assert property ($changed(channel_irq_enable) |-> $rose(bvalid))
		else $error("interrupt enable moved without a write");
	cover property (core_cal_start != 0);
	cover property (rvalid && a_q == ACCTR_OFS_CAL);
	cover property (channel_trigger[0]);
endmodule // acctr_regs_checker

bind acctr_regs acctr_regs_checker u_chk (.aclk(aclk), .aresetn(aresetn), .araddr(araddr),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .bresp(bresp),
	.bvalid(bvalid), .bready(bready), .result_done(result_done), .buffer_read(buffer_read),
	.core_cal_start(core_cal_start), .channel_irq_enable(channel_irq_enable),
	.result_ready_flag(result_ready_flag), .channel_trigger(channel_trigger));

// [tb/acctr_regs_test.sv]
`timescale 1ns/1ns
module acctr_regs_test
	import acctr_pkg::*;
;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, external_trigger_input;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, cal_finished, core_cal_start, core_cal_diffmode;
	logic [21:0] result_done, buffer_read, channel_irq_enable, result_ready_flag, channel_trigger;
	logic [5:0] differential_select, sign_select;
	acctr_evt_t trigger_events, v;
	int n_errors, check_count, cyc, n_cal, n_t0, k;
	acctr_regs uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .trigger_events, .external_trigger_input, .result_done,
		.buffer_read, .cal_finished, .core_cal_start, .core_cal_diffmode,
		.differential_select, .sign_select, .channel_irq_enable, .result_ready_flag,
		.channel_trigger);
	// ------------------------------------------------------------
	// clock, watchdog, monitors
	// ------------------------------------------------------------
	initial aclk = 1'b0;
	always #50 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			conclude();
		end
	end
	// pulses counted at the falling edge, clear of launch races
	always @(negedge aclk) begin
		n_cal += core_cal_start[0] + core_cal_start[1];
		n_t0 += channel_trigger[0];
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
		check({30'h0, r}, {30'h0, er});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
		check(d, e);
		check({30'h0, r}, {30'h0, er});
	endtask
	task automatic ev(input acctr_evt_t x, input logic e);
		@(posedge aclk);
		trigger_events <= x;
		@(posedge aclk);
		@(negedge aclk);
		check({31'h0, channel_trigger[0]}, {31'h0, e});
	endtask
	function automatic int eb(input int c);
		if (c == 4) return 26;
		if (c <= 10) return c + 15;
		if (c <= 13) return 30 - c;
		if (c == 14) return 16;
		if (c <= 20) return c - 5;
		if (c <= 23) return 30 - c;
		if (c <= 29) return c - 23;
		return 0;
	endfunction
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic t_reset_and_map();
		for (int i = 0; i < 19; i++)
			rd(8'((i < 7) ? i * 4 : 32 + (i - 7) * 4), 32'h0, ACCTR_RESP_OKAY);
		rd(8'h1C, 32'h0, ACCTR_RESP_SLVERR);
		wr(8'h50, 16'hFFFF, ACCTR_RESP_SLVERR);
	endtask
	task automatic t_mode_irq();
		wr(ACCTR_OFS_MODE, 16'hF5A6, ACCTR_RESP_OKAY);
		rd(ACCTR_OFS_MODE, 32'h05A6, ACCTR_RESP_OKAY);
		check({26'h0, differential_select}, 32'h0D);
		check({26'h0, sign_select}, 32'h32);
		wr(ACCTR_OFS_IE_LO, 16'hA5C3, ACCTR_RESP_OKAY);
		wr(ACCTR_OFS_IE_HI, 16'hFFFF, ACCTR_RESP_OKAY);
		rd(ACCTR_OFS_IE_LO, 32'hA5C3, ACCTR_RESP_OKAY);
		rd(ACCTR_OFS_IE_HI, 32'h003F, ACCTR_RESP_OKAY);
		check({10'h0, channel_irq_enable}, 32'h003FA5C3);
	endtask
	task automatic t_ready();
		@(posedge aclk) result_done <= 22'h200001;
		@(posedge aclk) result_done <= 22'h000000;
		wr(ACCTR_OFS_RDY_LO, 16'h0000, ACCTR_RESP_OKAY);
		rd(ACCTR_OFS_RDY_LO, 32'h0001, ACCTR_RESP_OKAY);
		rd(ACCTR_OFS_RDY_HI, 32'h0020, ACCTR_RESP_OKAY);
		check({10'h0, result_ready_flag}, 32'h00200001);
		@(posedge aclk) buffer_read <= 22'h000001;
		@(posedge aclk) buffer_read <= 22'h000000;
		rd(ACCTR_OFS_RDY_LO, 32'h0000, ACCTR_RESP_OKAY);
		check({10'h0, result_ready_flag}, 32'h00200000);
	endtask
	task automatic t_trig();
		for (int c = 4; c < 31; c++) begin
			wr(ACCTR_OFS_TRIG, 16'(c), ACCTR_RESP_OKAY);
			v = acctr_evt_t'(27'h1 << eb(c));
			ev(v, 1'b1);
			ev(~v, 1'b0);
		end
		wr(ACCTR_OFS_TRIG, 16'hFFE3, ACCTR_RESP_OKAY);
		rd(ACCTR_OFS_TRIG, 32'h1F03, ACCTR_RESP_OKAY);
		ev('1, 1'b0);
		wr(ACCTR_OFS_TRIG, 16'h001F, ACCTR_RESP_OKAY);
		ev('0, 1'b0);
		@(posedge aclk) external_trigger_input <= 1'b1;
		repeat (8) @(posedge aclk);
		@(negedge aclk);
		check({31'h0, channel_trigger[0]}, 32'h1);
		wr(ACCTR_OFS_SWTRG, 16'h0002, ACCTR_RESP_OKAY);
		wr(ACCTR_OFS_TRIG + 8'h04, 16'h0202, ACCTR_RESP_OKAY);
		wr(ACCTR_OFS_TRIG + 8'h28, 16'h0202, ACCTR_RESP_OKAY);
		wr(ACCTR_OFS_TRIG, 16'h0001, ACCTR_RESP_OKAY);
		external_trigger_input <= 1'b0;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		check({10'h0, channel_trigger}, 32'h0030000C);
		rd(ACCTR_OFS_TRIG + 8'h28, 32'h0202, ACCTR_RESP_OKAY);
		k = n_t0;
		wr(ACCTR_OFS_SWTRG, 16'h0001, ACCTR_RESP_OKAY);
		repeat (3) @(posedge aclk);
		check(32'(n_t0 - k), 32'h1);
	endtask
	task automatic t_cal();
		wr(ACCTR_OFS_CAL, 16'h0505, ACCTR_RESP_OKAY);
		rd(ACCTR_OFS_CAL, 32'h0, ACCTR_RESP_OKAY);
		wr(ACCTR_OFS_CAL, 16'h0202, ACCTR_RESP_OKAY);
		rd(ACCTR_OFS_CAL, 32'h0202, ACCTR_RESP_OKAY);
		wr(ACCTR_OFS_CAL, 16'h0707, ACCTR_RESP_OKAY);
		rd(ACCTR_OFS_CAL, 32'h0707, ACCTR_RESP_OKAY);
		check(32'(n_cal), 32'h2);
		check({30'h0, core_cal_diffmode}, 32'h3);
		@(posedge aclk) cal_finished <= 2'b01;
		@(posedge aclk) cal_finished <= 2'b00;
		rd(ACCTR_OFS_CAL, 32'h0786, ACCTR_RESP_OKAY);
		@(posedge aclk) cal_finished <= 2'b10;
		@(posedge aclk) cal_finished <= 2'b00;
		rd(ACCTR_OFS_CAL, 32'h8686, ACCTR_RESP_OKAY);
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		trigger_events = '0;
		external_trigger_input = 1'b0;
		result_done = 22'h0;
		buffer_read = 22'h0;
		cal_finished = 2'b00;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset_and_map();
		t_mode_irq();
		t_ready();
		t_trig();
		t_cal();
		conclude();
	end
endmodule // acctr_regs_test
